/* hdl/lbcs_pkg.sv */
package lbcs_pkg;

  // ==========================================================================
  // register map (byte addresses)
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_SLEEP     = 8'h04;
  localparam logic [7:0]  REG_WAKE      = 8'h08;
  localparam logic [7:0]  REG_STATUS    = 8'h0c;
  localparam logic [7:0]  REG_FSADJ     = 8'h10;
  localparam logic [7:0]  REG_OFS_BASE  = 8'h40;
  localparam logic [7:0]  REG_GAIN_BASE = 8'h60;
  localparam logic [7:0]  TRIM_SPAN     = 8'h18;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ==========================================================================
  // field layouts
  typedef struct packed {
    logic cal_enable;
    logic cal_status_select;
    logic spare_offset_reference;
    logic bg_offset_cal_enable;
    logic fg_offset_cal_enable;
    logic software_cal_trigger;
    logic pin_trigger_enable;
    logic manual_swap_select;
    logic lowpower_bg_enable;
    logic background_cal_enable;
  } lbcs_ctrl_type;

  typedef struct packed {
    logic       foreground_complete_flag;
    logic       spare_cal_finished;
    logic       cal_busy;
    logic [2:0] spare_b;
    logic [2:0] spare_a;
  } lbcs_status_type;

  localparam int            CTRL_W       = $bits(lbcs_ctrl_type);
  localparam int            STAT_W       = $bits(lbcs_status_type);
  localparam lbcs_ctrl_type CTRL_RESET   = 10'h210;
  localparam int            DLY_W        = 16;
  localparam int            TRIM_W       = 16;
  localparam logic [15:0]   SLEEP_RESET  = 16'h0010;
  localparam logic [15:0]   WAKE_RESET   = 16'h0004;
  localparam logic [15:0]   FSADJ_RESET  = 16'ha000;

  // ==========================================================================
  // cores and trim memory layout
  localparam int          MEM_DEPTH    = 16;
  localparam int          MEM_AW       = 4;
  localparam logic [3:0]  GAIN_IDX     = 4'h8;
  localparam logic [2:0]  NUM_CORES    = 3'd6;
  localparam logic [2:0]  CORE_NONE    = 3'd7;
  localparam logic [2:0]  SPARE_A      = 3'd2;
  localparam logic [2:0]  SPARE_B      = 3'd3;
  localparam logic [5:0]  USED_QUAD    = 6'h3f;
  localparam logic [5:0]  USED_DUAL    = 6'h07;
  localparam logic [5:0]  USED_SINGLE  = 6'h05;
  localparam logic [5:0]  MAIN_CORES   = 6'h33;

  // ==========================================================================
  // timing: delay settings count in units of one microsecond
  localparam int          CLK_PERIOD_NS = 5;
  localparam int          DLY_UNIT_NS   = 1000;
  localparam int          DLY_UNIT_CYC  = (DLY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          UNIT_W        = 8;

endpackage

/* hdl/lbcs_trim_mem.sv */
`timescale 1ns/1ps
`default_nettype none

module lbcs_trim_mem #(
  parameter int DEPTH = 16,
  parameter int AW    = 4,
  parameter int WIDTH = 16
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_we,
  input  wire logic [AW-1:0]    i_waddr,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic             i_re,
  input  wire logic [AW-1:0]    i_raddr,
  output var  logic [WIDTH-1:0] o_rdata
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // ==========================================================================
  // storage, one word per core trim
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  // ==========================================================================
  // registered read
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_rdata <= '0;
    end else if (i_re) begin
      o_rdata <= mem_q[i_raddr];
    end
  end

endmodule

`default_nettype wire

/* hdl/lbcs_sequencer.sv */
// Overview of operation
// - low-power mode keeps spare asleep until due
// - swap-select bit picks manual or automatic
// - auto mode sleeps for the sleep interval
// - wait settle interval after wake before calibrating
// - auto mode swaps at once, spare sleeps
// - manual mode sleeps while trigger high
// - manual low trigger wakes, calibrates after settle
// - manual swap needs calibration done, trigger high
// - trigger held low keeps spare powered, unswapped
// - status select one shows spare finished
// - foreground offset correction once per foreground run
// - background offset correction on every background calibration
// - offset bit before enable gives one-time correction
// - device writes offset trims, host writes refused while an offset enable is set
// - foreground with background and foreground offset enabled calibrates all used cores, six with four inputs
// - offset reference option matches mains to spare
// - unused inputs' trims have no effect
// - separate offset trim per core
// - one full-scale adjust for all inputs
// - trigger source is pin or software bit
`timescale 1ns/1ps
`default_nettype none

module lbcs_sequencer #(
  parameter int NUM_INPUTS = 4,
  parameter int CAL_CYCLES = 1024
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output var  logic        o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output var  logic        o_wready,
  output var  logic [1:0]  o_bresp,
  output var  logic        o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output var  logic        o_arready,
  output var  logic [31:0] o_rdata,
  output var  logic [1:0]  o_rresp,
  output var  logic        o_rvalid,
  input  wire logic        i_rready,
  input  wire logic        i_cal_trigger_pin,
  input  wire logic [15:0] i_offset_measure,
  output var  logic        o_cal_status_pin,
  output var  logic [5:0]  o_core_awake,
  output var  logic [5:0]  o_core_online,
  output var  logic [2:0]  o_cal_core,
  output var  logic        o_cal_run,
  output var  logic        o_core_swap,
  output var  logic [15:0] o_full_scale_adjust
);

  localparam int CAL_W = $clog2(CAL_CYCLES + 1);
  localparam logic [CAL_W-1:0]  CAL_LAST  = CAL_W'(CAL_CYCLES - 1);
  localparam logic [7:0] UNIT_LAST = 8'(lbcs_pkg::DLY_UNIT_CYC - 1);
  localparam logic [5:0] USED_MASK = (NUM_INPUTS == 4) ? lbcs_pkg::USED_QUAD :
                                     (NUM_INPUTS == 2) ? lbcs_pkg::USED_DUAL :
                                                         lbcs_pkg::USED_SINGLE;
  localparam logic       QUAD      = (NUM_INPUTS == 4);
  localparam logic       SINGLE    = (NUM_INPUTS == 1);

  if (!(NUM_INPUTS == 1 || NUM_INPUTS == 2 || NUM_INPUTS == 4) || CAL_CYCLES < 1) begin : g_chk
    $error("lbcs_sequencer: NUM_INPUTS must be 1, 2 or 4 and CAL_CYCLES positive");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_FG_CAL, ST_BG_SLEEP, ST_BG_WAKE, ST_BG_CAL, ST_BG_HOLD
  } lbcs_state_type;

  // ==========================================================================
  // helpers
  function automatic logic [5:0] onehot(input logic [2:0] c);
    return 6'h01 << c;
  endfunction

  function automatic logic [2:0] core_after(input logic [5:0] m, input logic [2:0] cur);
    logic [2:0] r;
    r = lbcs_pkg::CORE_NONE;
    for (int i = 5; i >= 0; i--) begin
      if (m[i] && 3'(i) > cur) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] first_core(input logic [5:0] m);
    logic [2:0] r;
    r = lbcs_pkg::CORE_NONE;
    for (int i = 5; i >= 0; i--) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] rotate(input logic [2:0] c, input logic single);
    case (c)
      3'd2:    rotate = 3'd0;
      3'd0:    rotate = single ? 3'd2 : 3'd1;
      3'd1:    rotate = 3'd2;
      3'd3:    rotate = 3'd4;
      3'd4:    rotate = 3'd5;
      3'd5:    rotate = 3'd3;
      default: rotate = 3'd2;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // state
  lbcs_pkg::lbcs_ctrl_type ctrl_q;
  logic [15:0]             sleep_q, wake_q, fsadj_q;
  lbcs_state_type          st_q;
  logic [15:0]             dly_q, ref_q;
  logic [7:0]              unit_q;
  logic [CAL_W-1:0]        cal_q;
  logic [2:0]              fg_core_q, spare_a_q, spare_b_q;
  logic                    grp_q, foreground_complete_flag_q, finished_q, cal_en_prev_q, trig_prev_q;
  logic                    pin_s1_q, pin_s2_q, pin_s3_q, pin_flt_q;
  logic [7:0]              awaddr_q, rd_addr_q;
  logic [31:0]             wdata_q;
  logic [3:0]              wstrb_q;
  logic                    aw_have_q, w_have_q, rd_pend_q;
  logic [15:0]             mem_rdata;

  // ==========================================================================
  // trigger source and pin filter
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      pin_s1_q  <= 1'b0;
      pin_s2_q  <= 1'b0;
      pin_s3_q  <= 1'b0;
      pin_flt_q <= 1'b0;
    end else begin
      pin_s1_q <= i_cal_trigger_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_s2_q == pin_s3_q) begin
        pin_flt_q <= pin_s3_q;
      end
    end
  end

  wire eff_trig   = ctrl_q.pin_trigger_enable ? pin_flt_q : ctrl_q.software_cal_trigger;
  wire bg_en      = ctrl_q.background_cal_enable;
  wire lp         = ctrl_q.lowpower_bg_enable;
  wire manual_lp  = lp && ctrl_q.manual_swap_select;
  wire tick       = (unit_q == 8'h00);
  wire cal_done   = (cal_q == '0);
  wire fg_start   = (ctrl_q.cal_enable && !cal_en_prev_q) || (!bg_en && eff_trig && !trig_prev_q);
  wire [5:0] fg_mask = (bg_en && ctrl_q.fg_offset_cal_enable) ? USED_MASK :
                       (USED_MASK & lbcs_pkg::MAIN_CORES);
  wire [2:0] fg_next   = core_after(fg_mask, fg_core_q);
  wire [2:0] cur_spare = grp_q ? spare_b_q : spare_a_q;
  wire [2:0] cal_core  = (st_q == ST_FG_CAL) ? fg_core_q : cur_spare;
  wire       is_spare  = (cal_core == lbcs_pkg::SPARE_A) || (cal_core == lbcs_pkg::SPARE_B);
  wire       ofs_use   = ctrl_q.fg_offset_cal_enable || ctrl_q.bg_offset_cal_enable;
  wire       seq_cal   = (st_q == ST_FG_CAL) || (st_q == ST_BG_CAL);
  wire       ofs_now   = (st_q == ST_FG_CAL) ? ctrl_q.fg_offset_cal_enable :
                                               ctrl_q.bg_offset_cal_enable;
  wire       spare_offset_reference_sp  = ctrl_q.spare_offset_reference && is_spare;
  wire       seq_we    = seq_cal && cal_done && ofs_now && !spare_offset_reference_sp;
  wire [15:0] ofs_val  = ctrl_q.spare_offset_reference ? 16'(ref_q - i_offset_measure) :
                                                         16'(16'h0000 - i_offset_measure);
  wire       swap_now  = ((st_q == ST_BG_CAL) && cal_done && (!manual_lp || eff_trig)) ||
                         ((st_q == ST_BG_HOLD) && eff_trig);
  lbcs_state_type bg_entry;
  assign bg_entry = lp ? ST_BG_SLEEP : ST_BG_CAL;

  // ==========================================================================
  // sequencer
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_q          <= ST_IDLE;
      dly_q         <= '0;
      unit_q        <= '0;
      cal_q         <= '0;
      ref_q         <= '0;
      fg_core_q     <= '0;
      spare_a_q     <= lbcs_pkg::SPARE_A;
      spare_b_q     <= lbcs_pkg::SPARE_B;
      grp_q         <= 1'b0;
      foreground_complete_flag_q     <= 1'b0;
      finished_q    <= 1'b0;
      cal_en_prev_q <= 1'b0;
      trig_prev_q   <= 1'b0;
    end else begin
      cal_en_prev_q <= ctrl_q.cal_enable;
      trig_prev_q   <= eff_trig;
      unit_q        <= tick ? UNIT_LAST : 8'(unit_q - 8'h01);
      if (seq_cal && !cal_done) begin
        cal_q <= CAL_W'(cal_q - 1'b1);
      end
      if (seq_cal && cal_done && spare_offset_reference_sp) begin
        ref_q <= i_offset_measure;
      end
      if (swap_now) begin
        if (grp_q) begin
          spare_b_q <= rotate(spare_b_q, SINGLE);
        end else begin
          spare_a_q <= rotate(spare_a_q, SINGLE);
        end
        grp_q      <= QUAD ? !grp_q : 1'b0;
        finished_q <= (st_q == ST_BG_CAL);
        st_q       <= bg_en ? bg_entry : ST_IDLE;
        dly_q      <= sleep_q;
        cal_q      <= CAL_LAST;
        unit_q     <= UNIT_LAST;
      end else begin
        case (st_q)
          ST_IDLE: begin
            if (fg_start) begin
              st_q      <= ST_FG_CAL;
              fg_core_q <= first_core(fg_mask);
              cal_q     <= CAL_LAST;
              foreground_complete_flag_q <= 1'b0;
            end else if (bg_en && foreground_complete_flag_q) begin
              st_q   <= bg_entry;
              dly_q  <= sleep_q;
              cal_q  <= CAL_LAST;
              unit_q <= UNIT_LAST;
            end
          end
          ST_FG_CAL: begin
            if (cal_done) begin
              if (fg_next == lbcs_pkg::CORE_NONE) begin
                foreground_complete_flag_q <= 1'b1;
                st_q      <= bg_en ? bg_entry : ST_IDLE;
                dly_q     <= sleep_q;
                unit_q    <= UNIT_LAST;
              end else begin
                fg_core_q <= fg_next;
              end
              cal_q <= CAL_LAST;
            end
          end
          ST_BG_SLEEP: begin
            if (!bg_en) begin
              st_q <= ST_IDLE;
            end else if (manual_lp ? !eff_trig : (tick && dly_q == 16'h0000)) begin
              st_q   <= ST_BG_WAKE;
              dly_q  <= wake_q;
              unit_q <= UNIT_LAST;
            end else if (!manual_lp && tick) begin
              dly_q <= 16'(dly_q - 16'h0001);
            end
          end
          ST_BG_WAKE: begin
            if (tick && dly_q == 16'h0000) begin
              st_q  <= ST_BG_CAL;
              cal_q <= CAL_LAST;
            end else if (tick) begin
              dly_q <= 16'(dly_q - 16'h0001);
            end
          end
          ST_BG_CAL: begin
            if (cal_done) begin
              finished_q <= 1'b1;
              st_q       <= ST_BG_HOLD;
            end
          end
          ST_BG_HOLD: begin
            finished_q <= 1'b1;
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ==========================================================================
  // core power and output drive
  wire bg_act    = (st_q == ST_BG_WAKE) || (st_q == ST_BG_CAL) || (st_q == ST_BG_HOLD);
  wire spare_on_a = (st_q != ST_IDLE) && (!lp || (bg_act && !grp_q));
  wire spare_on_b = QUAD && (st_q != ST_IDLE) && (!lp || (bg_act && grp_q));
  wire [5:0] online = USED_MASK & ~onehot(spare_a_q) & ~onehot(spare_b_q);
  wire [5:0] awake  = (st_q == ST_FG_CAL) ? USED_MASK :
                      (online | (spare_on_a ? onehot(spare_a_q) : 6'h00) |
                       (spare_on_b ? onehot(spare_b_q) : 6'h00));
  wire status_pin   = ctrl_q.cal_status_select ? finished_q : seq_cal;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_core_awake     <= '0;
      o_core_online    <= '0;
      o_cal_core       <= '0;
      o_cal_run        <= 1'b0;
      o_core_swap      <= 1'b0;
      o_cal_status_pin <= 1'b0;
    end else begin
      o_core_awake     <= awake;
      o_core_online    <= (st_q == ST_FG_CAL) ? 6'h00 : online;
      o_cal_core       <= cal_core;
      o_cal_run        <= seq_cal;
      o_core_swap      <= swap_now;
      o_cal_status_pin <= status_pin;
    end
  end

  // ==========================================================================
  // register bus: write path
  wire       aw_hs   = i_awvalid && o_awready;
  wire       w_hs    = i_wvalid && o_wready;
  wire [7:0] w_off   = awaddr_q - lbcs_pkg::REG_OFS_BASE;
  wire [7:0] w_goff  = awaddr_q - lbcs_pkg::REG_GAIN_BASE;
  wire       w_ofs   = (awaddr_q >= lbcs_pkg::REG_OFS_BASE) && (w_off < lbcs_pkg::TRIM_SPAN);
  wire       w_gain  = (awaddr_q >= lbcs_pkg::REG_GAIN_BASE) && (w_goff < lbcs_pkg::TRIM_SPAN);
  wire       w_ctrl  = (awaddr_q[7:2] == lbcs_pkg::REG_CTRL[7:2]);
  wire       w_sleep = (awaddr_q[7:2] == lbcs_pkg::REG_SLEEP[7:2]);
  wire       w_wake  = (awaddr_q[7:2] == lbcs_pkg::REG_WAKE[7:2]);
  wire       w_fs    = (awaddr_q[7:2] == lbcs_pkg::REG_FSADJ[7:2]);
  wire       w_ok    = w_ctrl || w_sleep || w_wake || w_fs || w_gain || (w_ofs && !ofs_use);
  wire       wr_do   = aw_have_q && w_have_q && !o_bvalid && !seq_we;
  wire       bus_mwe = wr_do && (w_gain || (w_ofs && !ofs_use));
  wire [3:0] bus_idx = w_gain ? (lbcs_pkg::GAIN_IDX | {1'b0, w_goff[4:2]}) : {1'b0, w_off[4:2]};
  wire [31:0] ctrl_w = merge({22'h0, ctrl_q}, wdata_q, wstrb_q);
  wire [31:0] sl_w   = merge({16'h0, sleep_q}, wdata_q, wstrb_q);
  wire [31:0] wk_w   = merge({16'h0, wake_q}, wdata_q, wstrb_q);
  wire [31:0] fs_w   = merge({16'h0, fsadj_q}, wdata_q, wstrb_q);

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= lbcs_pkg::RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      ctrl_q    <= lbcs_pkg::CTRL_RESET;
      sleep_q   <= lbcs_pkg::SLEEP_RESET;
      wake_q    <= lbcs_pkg::WAKE_RESET;
      fsadj_q   <= lbcs_pkg::FSADJ_RESET;
    end else begin
      o_awready <= !aw_hs && !aw_have_q && !o_bvalid;
      o_wready  <= !w_hs && !w_have_q && !o_bvalid;
      if (aw_hs) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= i_awaddr;
      end
      if (w_hs) begin
        w_have_q <= 1'b1;
        wdata_q  <= i_wdata;
        wstrb_q  <= i_wstrb;
      end
      if (wr_do) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= w_ok ? lbcs_pkg::RESP_OKAY : lbcs_pkg::RESP_SLVERR;
        if (w_ctrl) begin
          ctrl_q <= lbcs_pkg::lbcs_ctrl_type'(ctrl_w[lbcs_pkg::CTRL_W-1:0]);
        end
        if (w_sleep) begin
          sleep_q <= sl_w[15:0];
        end
        if (w_wake) begin
          wake_q <= wk_w[15:0];
        end
        if (w_fs) begin
          fsadj_q <= fs_w[15:0];
        end
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  assign o_full_scale_adjust = fsadj_q;

  // ==========================================================================
  // register bus: read path
  wire       ar_hs  = i_arvalid && o_arready;
  wire [7:0] r_off  = i_araddr - lbcs_pkg::REG_OFS_BASE;
  wire [7:0] r_goff = i_araddr - lbcs_pkg::REG_GAIN_BASE;
  wire [3:0] r_idx  = (i_araddr >= lbcs_pkg::REG_GAIN_BASE) ?
                      (lbcs_pkg::GAIN_IDX | {1'b0, r_goff[4:2]}) : {1'b0, r_off[4:2]};
  wire [7:0] q_off  = rd_addr_q - lbcs_pkg::REG_OFS_BASE;
  wire [7:0] q_goff = rd_addr_q - lbcs_pkg::REG_GAIN_BASE;
  wire       r_trim = ((rd_addr_q >= lbcs_pkg::REG_OFS_BASE) && (q_off < lbcs_pkg::TRIM_SPAN)) ||
                      ((rd_addr_q >= lbcs_pkg::REG_GAIN_BASE) && (q_goff < lbcs_pkg::TRIM_SPAN));
  lbcs_pkg::lbcs_status_type stat;
  assign stat = '{foreground_complete_flag: foreground_complete_flag_q, spare_cal_finished: finished_q,
                  cal_busy: seq_cal, spare_b: spare_b_q, spare_a: spare_a_q};
  logic [31:0] r_word;
  logic        r_ok;

  always_comb begin
    r_ok   = 1'b1;
    r_word = 32'h0000_0000;
    case (rd_addr_q[7:2])
      lbcs_pkg::REG_CTRL[7:2]:   r_word = {22'h0, ctrl_q};
      lbcs_pkg::REG_SLEEP[7:2]:  r_word = {16'h0, sleep_q};
      lbcs_pkg::REG_WAKE[7:2]:   r_word = {16'h0, wake_q};
      lbcs_pkg::REG_STATUS[7:2]: r_word = {23'h0, stat};
      lbcs_pkg::REG_FSADJ[7:2]:  r_word = {16'h0, fsadj_q};
      default: begin
        r_ok   = r_trim;
        r_word = r_trim ? {16'h0, mem_rdata} : 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= lbcs_pkg::RESP_OKAY;
      rd_pend_q <= 1'b0;
      rd_addr_q <= '0;
    end else begin
      o_arready <= !ar_hs && !rd_pend_q && !o_rvalid;
      if (ar_hs) begin
        rd_pend_q <= 1'b1;
        rd_addr_q <= i_araddr;
      end else if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        o_rvalid  <= 1'b1;
        o_rdata   <= r_word;
        o_rresp   <= r_ok ? lbcs_pkg::RESP_OKAY : lbcs_pkg::RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // per-core trim storage
  lbcs_trim_mem #(
    .DEPTH (lbcs_pkg::MEM_DEPTH),
    .AW    (lbcs_pkg::MEM_AW),
    .WIDTH (lbcs_pkg::TRIM_W)
  ) u_trim (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_we      (seq_we || bus_mwe),
    .i_waddr   (seq_we ? {1'b0, cal_core} : bus_idx),
    .i_wdata   (seq_we ? ofs_val : wdata_q[15:0]),
    .i_re      (ar_hs),
    .i_raddr   (r_idx),
    .o_rdata   (mem_rdata)
  );

endmodule

`default_nettype wire

/* dv/lbcs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lbcs_host_model (
  input  wire logic i_sys_clk,
  input  wire logic i_level,
  output var  logic o_cal_trigger_pin
);
  // ====================
  // trigger pin, moved off the clock edge
  initial o_cal_trigger_pin = 1'b1;
  always @(posedge i_sys_clk) o_cal_trigger_pin <= #1.3 i_level;
endmodule
`default_nettype wire

/* dv/lbcs_sequencer_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module lbcs_sequencer_asserts (
  input wire logic       i_sys_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_awvalid,
  input wire logic       i_wvalid,
  input wire logic       i_bready,
  input wire logic       i_arvalid,
  input wire logic       i_rready,
  input wire logic       o_awready,
  input wire logic       o_wready,
  input wire logic       o_bvalid,
  input wire logic [1:0] o_bresp,
  input wire logic       o_arready,
  input wire logic       o_rvalid,
  input wire logic [5:0] o_core_awake,
  input wire logic [2:0] o_cal_core,
  input wire logic       o_cal_run,
  input wire logic       o_core_swap
);
  // ====================
  // bus and sequencer relations
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  property p_bhold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold; o_rvalid && !i_rready |=> o_rvalid; endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_blat; i_awvalid && o_awready && i_wvalid && o_wready |-> ##[2:3] o_bvalid; endproperty
  a_blat: assert property (p_blat) else $error("write response late");
  property p_rlat; i_arvalid && o_arready |-> ##2 o_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read data late");
  property p_wbusy; o_bvalid |-> !o_awready && !o_wready; endproperty
  a_wbusy: assert property (p_wbusy) else $error("write accepted while busy");
  property p_rbusy; o_rvalid |-> !o_arready; endproperty
  a_rbusy: assert property (p_rbusy) else $error("read accepted while busy");
  property p_swap; o_core_swap |=> !o_core_swap; endproperty
  a_swap: assert property (p_swap) else $error("swap pulse too long");
  property p_calpwr; o_cal_run |-> o_core_awake[o_cal_core]; endproperty
  a_calpwr: assert property (p_calpwr) else $error("core calibrated unpowered");
endmodule
`default_nettype wire

/* dv/lbcs_sequencer_test.sv */
`timescale 1ns/1ps
`default_nettype none
module lbcs_sequencer_test;
  // ====================
  // stimulus, outputs and bookkeeping
  logic        i_sys_clk = 1'b0, i_sys_rst = 1'b1, lvl = 1'b1, i_cal_trigger_pin;
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic        i_arvalid = 1'b0, i_rready = 1'b0, o_cal_status_pin, o_cal_run, o_core_swap;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0, lf = 32'h4c1e, o_rdata;
  logic [15:0] i_offset_measure = 16'h0, o_full_scale_adjust, g;
  logic [3:0]  i_wstrb = 4'hf;
  logic [1:0]  o_bresp, o_rresp;
  logic [5:0]  o_core_awake, o_core_online;
  logic [2:0]  o_cal_core;
  logic [33:0] q[$];
  int          failures = 0, checks_done = 0, swaps = 0, t = 0, last = 0, gap = 0;
  always #2.5 i_sys_clk = ~i_sys_clk;
  lbcs_sequencer #(.CAL_CYCLES(16)) i_dut (.*);
  lbcs_host_model i_host (.i_sys_clk, .i_level(lvl), .o_cal_trigger_pin(i_cal_trigger_pin));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic cmp(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge i_sys_clk);
    q.push_back({r, 32'h0});
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      ta = ta || o_awready;
      tw = tw || o_wready;
    end while (!(ta && tw));
    do @(posedge i_sys_clk); while (!o_bvalid);
    i_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge i_sys_clk);
    q.push_back({r, d});
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do @(posedge i_sys_clk); while (!o_arready);
    i_arvalid <= 1'b0;
    do @(posedge i_sys_clk); while (!o_rvalid);
    i_rready <= 1'b0;
  endtask
  always @(posedge i_sys_clk) begin
    t <= t + 1;
    lf <= nxt(lf);
    i_offset_measure <= lf[15:0];
    if (o_core_swap) begin
      swaps <= swaps + 1;
      gap <= t - last;
      last <= t;
    end
    if (o_bvalid && i_bready) cmp({o_bresp, 32'h0}, q.pop_front());
    if (o_rvalid && i_rready) cmp({o_rresp, o_rdata}, q.pop_front());
  end
  initial begin
    #60000;
    failures++;
    test_done;
  end
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    repeat (200) @(posedge i_sys_clk);
    g = lf[15:0];
    rd(8'h10, 32'ha000, 2'h0);
    rd(8'h24, 32'h0, 2'h2);
    rd(8'h0c, 32'h11a, 2'h0);
    rd(8'h40, 32'h0, 2'h0);
    wr(8'h64, {16'h0, g}, 2'h0);
    wr(8'h04, 32'h2, 2'h0);
    wr(8'h08, 32'h1, 2'h0);
    wr(8'h00, 32'h14f, 2'h0);
    wr(8'h48, 32'h5555, 2'h2);
    wr(8'h00, 32'h34f, 2'h0);
    repeat (900) @(posedge i_sys_clk);
    cmp(34'({o_cal_run, o_core_awake, o_core_online}), 34'({1'b0, 6'h33, 6'h33}));
    cmp(34'({o_cal_core, o_full_scale_adjust}), 34'({3'd2, 16'ha000}));
    lvl <= 1'b0;
    repeat (1200) @(posedge i_sys_clk);
    cmp(34'({swaps, o_cal_status_pin}), 34'h1);
    lvl <= 1'b1;
    repeat (20) @(posedge i_sys_clk);
    cmp(34'(swaps), 34'h1);
    wr(8'h00, 32'h353, 2'h0);
    while (swaps < 3) @(posedge i_sys_clk);
    cmp(34'(gap >= 600 && gap <= 1100), 34'h1);
    rd(8'h64, {16'h0, g}, 2'h0);
    test_done;
  end
endmodule
bind lbcs_sequencer lbcs_sequencer_asserts i_chk (.*);
`default_nettype wire
